// ---- common/blc_pkg.sv ----
package blc_pkg;
    // =====================================================
    // parameter index within the backlight control command
    localparam logic [3:0] PARAM_CTRL = 4'h0;
    localparam logic [3:0] PARAM_SHARE0 = 4'h1;
    localparam logic [3:0] PARAM_SHARE1 = 4'h2;
    localparam logic [3:0] PARAM_UPPER0 = 4'h3;
    localparam logic [3:0] PARAM_UPPER1 = 4'h4;
    localparam logic [3:0] PARAM_LOWER0 = 4'h5;
    localparam logic [3:0] PARAM_LOWER1 = 4'h6;
    // =====================================================
    // field positions and reset values
    localparam int ENABLE_BIT = 0;
    localparam int MODE_BIT = 1;
    localparam logic [4:0] SHARE_RESET = 5'h00;
    localparam logic [7:0] UPPER_RESET = 8'h3F;
    localparam logic [7:0] LOWER_RESET = 8'h10;
    localparam logic [7:0] GRAY_WHITE = 8'h3F;
    localparam logic [6:0] PERCENT_STEP = 7'h02;
    localparam logic [6:0] PERCENT_FULL = 7'h64;
    // =====================================================
    // selected parameter set
    typedef struct packed {
        logic [4:0] share;
        logic [7:0] upper;
        logic [7:0] lower;
    } blc_set_t;
endpackage

// ---- core/backlight_threshold_stats.sv ----
// Behaviour
// R1: mode select 0 uses the mode-0 pixel share target, mode-1 ignored.
// R2: mode select 1 uses the mode-1 pixel share target, mode-0 ignored.
// R3: share target code means code times two percent, 0 to 62.
// R4: share is count of pixels from threshold to 63 over all pixels.
// R5: upper limit code is the largest threshold grayscale, used directly.
// R6: upper limit comes from the field of the selected mode.
// R7: lower limit code is the smallest threshold grayscale, used directly.
// R8: lower limit comes from the field of the selected mode.
// R9: host keeps lower limit low bits above the coefficient minimum.
// R10: function runs only while the enable bit is one.
// R11: host clears enable before changing parameters or mode.
// R12: function stays off while display inversion is on.
// R13: each frame threshold is clamped between selected lower and upper limits, the lower limit winning when they cross.
module backlight_threshold_stats #(
    parameter int CNT_W = 20
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // command parameter write and read
    input wire logic param_wr,
    input wire logic [3:0] param_idx,
    input wire logic [7:0] param_wdata,
    output logic [7:0] param_rdata,
    // display state and pixel stream
    input wire logic invert_on,
    input wire logic frame_start,
    input wire logic pixel_valid,
    input wire logic [5:0] pixel_gray,
    // results
    output logic function_active,
    output logic [7:0] white_threshold,
    output logic threshold_valid
);
    // =====================================================
    // parameter registers
    logic enable_q, enable_d, mode_q, mode_d;
    logic [4:0] share0_q, share0_d, share1_q, share1_d;
    logic [7:0] upper0_q, upper0_d, upper1_q, upper1_d;
    logic [7:0] lower0_q, lower0_d, lower1_q, lower1_d;
    logic [7:0] rdata_q, rdata_d;
    blc_pkg::blc_set_t sel;

    always_comb begin
        enable_d = enable_q;
        mode_d = mode_q;
        share0_d = share0_q;
        share1_d = share1_q;
        upper0_d = upper0_q;
        upper1_d = upper1_q;
        lower0_d = lower0_q;
        lower1_d = lower1_q;
        if (param_wr) begin
            case (param_idx)
                blc_pkg::PARAM_CTRL: begin
                    enable_d = param_wdata[blc_pkg::ENABLE_BIT];
                    mode_d = param_wdata[blc_pkg::MODE_BIT];
                end
                blc_pkg::PARAM_SHARE0: share0_d = param_wdata[4:0];
                blc_pkg::PARAM_SHARE1: share1_d = param_wdata[4:0];
                blc_pkg::PARAM_UPPER0: upper0_d = param_wdata;
                blc_pkg::PARAM_UPPER1: upper1_d = param_wdata;
                blc_pkg::PARAM_LOWER0: lower0_d = param_wdata;
                blc_pkg::PARAM_LOWER1: lower1_d = param_wdata;
                default: ;
            endcase
        end
        case (param_idx)
            blc_pkg::PARAM_CTRL: rdata_d = {6'h00, mode_q, enable_q};
            blc_pkg::PARAM_SHARE0: rdata_d = {3'h0, share0_q};
            blc_pkg::PARAM_SHARE1: rdata_d = {3'h0, share1_q};
            blc_pkg::PARAM_UPPER0: rdata_d = upper0_q;
            blc_pkg::PARAM_UPPER1: rdata_d = upper1_q;
            blc_pkg::PARAM_LOWER0: rdata_d = lower0_q;
            blc_pkg::PARAM_LOWER1: rdata_d = lower1_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
            mode_q <= 1'b0;
            share0_q <= blc_pkg::SHARE_RESET;
            share1_q <= blc_pkg::SHARE_RESET;
            upper0_q <= blc_pkg::UPPER_RESET;
            upper1_q <= blc_pkg::UPPER_RESET;
            lower0_q <= blc_pkg::LOWER_RESET;
            lower1_q <= blc_pkg::LOWER_RESET;
            rdata_q <= 8'h00;
        end else begin
            enable_q <= enable_d;
            mode_q <= mode_d;
            share0_q <= share0_d;
            share1_q <= share1_d;
            upper0_q <= upper0_d;
            upper1_q <= upper1_d;
            lower0_q <= lower0_d;
            lower1_q <= lower1_d;
            rdata_q <= rdata_d;
        end
    end

    // =====================================================
    // mode selection
    always_comb begin
        if (mode_q) begin
            sel.share = share1_q; // see R2
            sel.upper = upper1_q; // see R6
            sel.lower = lower1_q; // see R8
        end else begin
            sel.share = share0_q; // see R1
            sel.upper = upper0_q; // see R6
            sel.lower = lower0_q; // see R8
        end
    end

    // =====================================================
    // histogram of one frame
    logic [CNT_W-1:0] hist_q [64];
    logic [CNT_W-1:0] hist_d [64];
    logic [CNT_W-1:0] total_q, total_d;
    logic active_q, active_d, frame_seen_q, frame_seen_d;
    logic [7:0] thr_q, thr_d;
    logic valid_q, valid_d;
    logic [7:0] raw_thr;
    logic [CNT_W+6:0] acc;
    logic [CNT_W+6:0] lhs;
    logic [CNT_W+6:0] rhs;

    function automatic logic [7:0] clamp_gray(input logic [7:0] v, input logic [7:0] lo,
                                              input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (r > hi) r = hi;
        if (r < lo) r = lo;
        return r;
    endfunction

    // highest threshold whose share of pixels reaches the target
    always_comb begin
        acc = '0;
        lhs = '0;
        raw_thr = 8'h00;
        rhs = (CNT_W+7)'(total_q) * (CNT_W+7)'(sel.share * blc_pkg::PERCENT_STEP); // see R3
        for (int g = 63; g >= 0; g--) begin
            acc = acc + (CNT_W+7)'(hist_q[g]); // see R4
            lhs = acc * (CNT_W+7)'(blc_pkg::PERCENT_FULL);
            if (raw_thr == 8'h00 && lhs >= rhs && rhs != '0) raw_thr = 8'(g);
        end
        if (rhs == '0) raw_thr = blc_pkg::GRAY_WHITE;
    end

    always_comb begin
        active_d = enable_q && !invert_on; // see R10 see R12
        frame_seen_d = frame_seen_q;
        total_d = total_q;
        thr_d = thr_q;
        valid_d = 1'b0;
        for (int g = 0; g < 64; g++) hist_d[g] = hist_q[g];
        if (!active_q) begin
            frame_seen_d = 1'b0;
            thr_d = 8'h00;
        end else if (frame_start) begin
            if (frame_seen_q) begin
                thr_d = clamp_gray(raw_thr, sel.lower, sel.upper); // see R5 see R7 see R13
                valid_d = 1'b1;
            end
            frame_seen_d = 1'b1;
            total_d = '0;
            for (int g = 0; g < 64; g++) hist_d[g] = '0;
        end else if (pixel_valid && frame_seen_q) begin
            hist_d[pixel_gray] = hist_q[pixel_gray] + CNT_W'(1);
            total_d = total_q + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active_q <= 1'b0;
            frame_seen_q <= 1'b0;
            total_q <= '0;
            thr_q <= 8'h00;
            valid_q <= 1'b0;
            for (int g = 0; g < 64; g++) hist_q[g] <= '0;
        end else begin
            active_q <= active_d;
            frame_seen_q <= frame_seen_d;
            total_q <= total_d;
            thr_q <= thr_d;
            valid_q <= valid_d;
            for (int g = 0; g < 64; g++) hist_q[g] <= hist_d[g];
        end
    end

    assign param_rdata = rdata_q;
    assign function_active = active_q;
    assign white_threshold = thr_q;
    assign threshold_valid = valid_q;

    // =====================================================
    // checks
    chk_inverted_off: assert property (@(posedge ref_clk) disable iff (rst) // see R12
        $past(invert_on) |-> !active_q) else $error("function active while inverted");
    chk_enable_off: assert property (@(posedge ref_clk) disable iff (rst) // see R10
        !$past(enable_q) |-> !active_q) else $error("function active while disabled");
    chk_clamp_upper: assert property (@(posedge ref_clk) disable iff (rst) // see R5
        valid_q |-> thr_q <= $past(sel.upper) || $past(sel.lower) > $past(sel.upper))
        else $error("threshold above upper limit");
    chk_clamp_lower: assert property (@(posedge ref_clk) disable iff (rst) // see R7
        valid_q |-> thr_q >= $past(sel.lower)) else $error("threshold below lower limit");
    chk_mode_share: assert property (@(posedge ref_clk) disable iff (rst) // see R1
        !mode_q |-> sel.share == share0_q) else $error("mode 0 share wrong");
    chk_mode1_share: assert property (@(posedge ref_clk) disable iff (rst) // see R2
        mode_q |-> sel.share == share1_q) else $error("mode 1 share wrong");
    chk_upper_select: assert property (@(posedge ref_clk) disable iff (rst) // see R6
        valid_q && $past(lower0_q) <= $past(upper0_q) && $past(lower1_q) <= $past(upper1_q)
        |-> thr_q <= ($past(mode_q) ? $past(upper1_q) : $past(upper0_q)))
        else $error("upper select wrong");
    chk_lower_select: assert property (@(posedge ref_clk) disable iff (rst) // see R8
        valid_q |-> thr_q >= ($past(mode_q) ? $past(lower1_q) : $past(lower0_q)))
        else $error("lower select wrong");
    chk_valid_pulse: assert property (@(posedge ref_clk) disable iff (rst) // see R13
        valid_q |-> $past(frame_start) && $past(active_q)) else $error("stray valid");
    chk_total_count: assert property (@(posedge ref_clk) disable iff (rst) // see R4
        $past(pixel_valid && active_q && frame_seen_q && !frame_start) && active_q
        |-> total_q == $past(total_q) + CNT_W'(1)) else $error("pixel not counted");
endmodule

// ---- bench/host_model.sv ----
// ==========================================
// host side writing and reading command parameters
module host_model (
    // clock
    input wire logic ref_clk,
    // parameter bus
    output logic param_wr,
    output logic [3:0] param_idx,
    output logic [7:0] param_wdata,
    input wire logic [7:0] param_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        param_wr = 1'b0;
        param_idx = 4'h0;
        param_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        param_wr <= 1'b1;
        param_idx <= idx;
        param_wdata <= d;
        @(posedge ref_clk);
        param_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] idx, output logic [7:0] d);
        @(posedge ref_clk);
        param_idx <= idx;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = param_rdata;
    endtask
    // coefficient stays at zero, so any lower level is allowed
    task automatic load(input logic m, input blc_pkg::blc_set_t s0, input blc_pkg::blc_set_t s1);
        wr(blc_pkg::PARAM_CTRL, 8'h00); // park the function first
        wr(blc_pkg::PARAM_SHARE0, {3'h0, s0.share});
        wr(blc_pkg::PARAM_SHARE1, {3'h0, s1.share});
        wr(blc_pkg::PARAM_UPPER0, s0.upper);
        wr(blc_pkg::PARAM_UPPER1, s1.upper);
        wr(blc_pkg::PARAM_LOWER0, s0.lower);
        wr(blc_pkg::PARAM_LOWER1, s1.lower);
        wr(blc_pkg::PARAM_CTRL, {6'h00, m, 1'b1});
    endtask
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, param_wr, invert_on, frame_start, pixel_valid;
    logic function_active, threshold_valid;
    logic [3:0] param_idx;
    logic [7:0] param_wdata, param_rdata, white_threshold, rd;
    logic [5:0] pixel_gray;
    logic [31:0] seed = 32'h29439186;
    logic [31:0] r;
    int miscompares = 0, n_compared = 0, cycles = 0, tot;
    int hist[64];
    blc_pkg::blc_set_t s0, s1;
    backlight_threshold_stats #(.CNT_W(20)) backlight_threshold_stats_inst (.ref_clk(ref_clk),
        .rst(rst), .param_wr(param_wr), .param_idx(param_idx), .param_wdata(param_wdata),
        .param_rdata(param_rdata), .invert_on(invert_on), .frame_start(frame_start),
        .pixel_valid(pixel_valid), .pixel_gray(pixel_gray), .function_active(function_active),
        .white_threshold(white_threshold), .threshold_valid(threshold_valid));
    host_model host_model_inst (.ref_clk(ref_clk), .param_wr(param_wr), .param_idx(param_idx),
        .param_wdata(param_wdata), .param_rdata(param_rdata));
    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int exp_thr(blc_pkg::blc_set_t s, int total);
        int t = -1;
        int acc = 0;
        for (int g = 63; g >= 0; g--) begin
            acc += hist[g];
            if (t < 0 && acc * 100 >= total * s.share * 2) t = g;
        end
        if (total == 0) t = int'(blc_pkg::GRAY_WHITE);
        if (t > s.upper) t = s.upper;
        if (t < s.lower) t = s.lower;
        return t;
    endfunction
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one frame of n pixels, the first four at gray 63 and the rest random, waits for the frame result
    task automatic frame(input int n);
        logic [5:0] g;
        int k;
        hist = '{default: 0};
        @(posedge ref_clk) frame_start <= 1'b1;
        @(posedge ref_clk) frame_start <= 1'b0;
        for (k = 0; k < n; k++) begin
            r = rnd();
            g = (k < 4) ? 6'h3F : r[5:0];
            hist[g]++;
            @(posedge ref_clk);
            pixel_valid <= 1'b1;
            pixel_gray <= g;
        end
        @(posedge ref_clk);
        pixel_valid <= 1'b0;
        frame_start <= 1'b1;
        @(posedge ref_clk) frame_start <= 1'b0;
        for (k = 0; k < 8 && threshold_valid !== 1'b1; k++) @(negedge ref_clk);
        tot = n;
    endtask
    // ==========================================
    // clock, timeout and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        rst = 1'b1;
        invert_on = 1'b0;
        frame_start = 1'b0;
        pixel_valid = 1'b0;
        pixel_gray = 6'h00;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        host_model_inst.rd(blc_pkg::PARAM_UPPER0, rd);
        check("upper0", blc_pkg::UPPER_RESET, rd);
        host_model_inst.rd(blc_pkg::PARAM_LOWER1, rd);
        check("lower1", blc_pkg::LOWER_RESET, rd);
        host_model_inst.rd(4'hF, rd);
        check("unmapped", 8'h00, rd);
        check("active", 8'h00, {7'h00, function_active});
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            s0 = r[20:0];
            s0.lower &= 8'h3F;
            r = rnd();
            s1 = r[20:0];
            s1.lower &= 8'h3F;
            if (i == 0) s0.share = 5'h1F;
            if (i == 1) s1.share = 5'h00;
            host_model_inst.load(i[0], s0, s1);
            host_model_inst.rd(blc_pkg::PARAM_SHARE1, rd);
            check("share1", {3'h0, s1.share}, rd);
            frame(40);
            check("valid", 8'h01, {7'h00, threshold_valid});
            check("threshold", 8'(exp_thr(i[0] ? s1 : s0, tot)), white_threshold);
        end
        @(posedge ref_clk) invert_on <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check("active", 8'h00, {7'h00, function_active});
        check("threshold", 8'h00, white_threshold);
        @(posedge ref_clk) invert_on <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check("active", 8'h01, {7'h00, function_active});
        host_model_inst.wr(blc_pkg::PARAM_CTRL, 8'h02);
        repeat (3) @(negedge ref_clk);
        check("active", 8'h00, {7'h00, function_active});
        @(posedge ref_clk) rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        host_model_inst.rd(blc_pkg::PARAM_UPPER1, rd);
        check("upper1", blc_pkg::UPPER_RESET, rd);
        host_model_inst.rd(blc_pkg::PARAM_CTRL, rd);
        check("ctrl", 8'h00, rd);
        check("threshold", 8'h00, white_threshold);
        end_sim();
    end
endmodule
